// ### hw/eeprom_spi_pkg.sv
/*
 Shared constants for the serial EEPROM command front end: opcodes,
 status bit positions, counts and the phase type.
 Assumes the front end runs on one 125 MHz clock.
*/
package eeprom_spi_pkg;
  // Opcodes with the ignored bit cleared
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  // Status bit positions
  localparam int ST_PEN = 7;
  localparam int ST_BPH = 3;
  localparam int ST_BPL = 2;
  localparam logic [2:0] RSV_BUSY = 3'h7;
  localparam logic [2:0] RSV_IDLE = 3'h0;
  // Nonvolatile bits start cleared
  localparam logic NV_RESET = 1'b0;
  // Byte framing
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] BYTES_FULL = 2'h3;
  localparam logic [1:0] ADDR_BYTES = 2'h2;
  // Internal write cycle time
  localparam int WRITE_MS = 5;
  localparam int CLOCK_KHZ = 125000;
  localparam int WRITE_CYCLES = WRITE_MS * CLOCK_KHZ;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {ph_idle, ph_opcode, ph_active, ph_invalid} phase_type;

  // Opcode match ignoring bit 3
  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
    return (op & OP_MASK) == code;
  endfunction

  // Protected quarters of the array per block-protect field
  function automatic logic [2:0] protect_quarters(input logic [1:0] bp);
    case (bp)
      2'h0: return 3'h0;
      2'h1: return 3'h1;
      2'h2: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction
endpackage

// ### hw/eeprom_spi_front_end.sv
/*
 Serial EEPROM command front end (slave) and its receive FIFO.
 Assumes all pins are asynchronous to clock; the master owns the serial
 clock, and the array data path sits behind the FIFO outside this file.
*/
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
    logic has_data;
    logic has_room;
    logic [WIDTH-1:0] head;
  } fifo_type;
  fifo_type q, n;
  logic push, pop;

  // Flags and head word come straight from registers
  assign in_ready = q.has_room;
  assign out_valid = q.has_data;
  assign out_data = q.head;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wr] = in_data;
      n.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      n.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    n.count = q.count + (PW+1)'(push) - (PW+1)'(pop);
    // Flags follow the next fill count, so full and empty stay exact
    n.has_data = n.count != '0;
    n.has_room = n.count != (PW+1)'(DEPTH);
    n.head = n.mem[n.rd];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.has_room <= 1'b1;
    end else begin
      q <= n;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module eeprom_spi_front_end
  import eeprom_spi_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic rx_overflow,
  output logic write_busy,
  output logic [2:0] array_quarters
);
  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic [1:0] si_s;
    logic [1:0] hold_s;
    logic [1:0] wp_s;
    logic sck_prev;
    phase_type phase;
    logic paused;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [7:0] tx;
    logic [2:0] out_cnt;
    logic reading;
    logic driving;
    logic wp_cancel;
    logic write_enable_latch;
    logic pen;
    logic bph;
    logic bpl;
    logic busy;
    logic [19:0] wc_cnt;
    logic so_out;
    logic so_oe;
    logic push;
    logic [7:0] push_data;
    logic overflow;
    logic [2:0] quarters;
  } state_type;
  state_type q, n;
  logic fifo_ready, rise, fall, prot, desel;
  logic [7:0] byte_in;

  // Status byte as read back
  function automatic logic [7:0] status_of(input state_type s);
    return {s.pen, s.busy ? RSV_BUSY : RSV_IDLE, s.bph, s.bpl, s.write_enable_latch, s.busy};
  endfunction

  // Clock edges found from the synchronised serial clock
  assign rise = q.sck_s[1] && !q.sck_prev;
  assign fall = !q.sck_s[1] && q.sck_prev;
  assign prot = !q.wp_s[1] && q.pen;
  assign desel = q.cs_s[1];
  assign byte_in = {q.shift[6:0], q.si_s[1]};

  always_comb begin
    n = q;
    // Two-flop synchronisers on every pin
    n.cs_s = {q.cs_s[0], cs_n};
    n.sck_s = {q.sck_s[0], sck};
    n.si_s = {q.si_s[0], si};
    n.hold_s = {q.hold_s[0], hold_n};
    n.wp_s = {q.wp_s[0], wp_n};
    n.sck_prev = q.sck_s[1];
    n.push = 1'b0;
    n.overflow = 1'b0;
    // Self-timed write cycle runs regardless of pause
    if (q.busy) begin
      if (q.wc_cnt == 20'(WRITE_CYCLES_P - 1)) begin
        n.busy = 1'b0;
        n.write_enable_latch = 1'b0;
      end else begin
        n.wc_cnt = q.wc_cnt + 20'h1;
      end
    end
    if (desel) begin
      // End of a selection period acts on the decoded opcode
      if (q.phase == ph_active) begin
        if (!q.hold_s[1]) begin
          n.write_enable_latch = 1'b0;
        end else if (op_is(q.opcode, OP_LATCH_SET)) begin
          n.write_enable_latch = 1'b1;
        end else if (op_is(q.opcode, OP_LATCH_CLEAR)) begin
          n.write_enable_latch = 1'b0;
        end else if (op_is(q.opcode, OP_STATUS_WRITE)) begin
          if (q.write_enable_latch && !q.wp_cancel && !prot && q.byte_cnt != '0 && q.bit_cnt == '0) begin
            n.pen = q.shift[ST_PEN];
            n.bph = q.shift[ST_BPH];
            n.bpl = q.shift[ST_BPL];
            n.busy = 1'b1;
            n.wc_cnt = '0;
          end
        end else if (op_is(q.opcode, OP_ARRAY_WRITE)) begin
          if (q.write_enable_latch && q.byte_cnt == BYTES_FULL && q.bit_cnt == '0) begin
            n.busy = 1'b1;
            n.wc_cnt = '0;
          end
        end
      end else if (q.phase != ph_idle && !q.hold_s[1]) begin
        n.write_enable_latch = 1'b0;
      end
      // Deselect clears the serial front end
      n.phase = ph_idle;
      n.bit_cnt = '0;
      n.byte_cnt = '0;
      n.paused = 1'b0;
      n.reading = 1'b0;
      n.driving = 1'b0;
      n.wp_cancel = 1'b0;
    end else begin
      if (q.phase == ph_idle) begin
        n.phase = ph_opcode;
      end
      // While selected, pause changes state only while the serial clock is low
      if (!q.sck_s[1]) begin
        n.paused = !q.hold_s[1];
      end
      if (prot) begin
        n.wp_cancel = 1'b1;
      end
      if (!q.paused && rise && q.phase != ph_invalid && q.phase != ph_idle) begin
        n.shift = byte_in;
        n.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == LAST_BIT) begin
          if (q.phase == ph_opcode) begin
            n.opcode = byte_in;
            n.phase = ph_invalid;
            if (op_is(byte_in, OP_STATUS_READ)) begin
              n.phase = ph_active;
              n.reading = 1'b1;
              n.tx = status_of(q);
              n.out_cnt = '0;
            end else if (!q.busy && (op_is(byte_in, OP_LATCH_SET) ||
                op_is(byte_in, OP_LATCH_CLEAR) || op_is(byte_in, OP_STATUS_WRITE) ||
                op_is(byte_in, OP_ARRAY_READ) || op_is(byte_in, OP_ARRAY_WRITE))) begin
              n.phase = ph_active;
            end
          end else begin
            if (q.byte_cnt != BYTES_FULL) begin
              n.byte_cnt = q.byte_cnt + 2'h1;
            end
            // Address and data bytes go to the array side
            if (op_is(q.opcode, OP_ARRAY_WRITE) ||
                (op_is(q.opcode, OP_ARRAY_READ) && q.byte_cnt < ADDR_BYTES)) begin
              n.push = fifo_ready;
              n.push_data = byte_in;
              n.overflow = !fifo_ready;
            end
          end
        end
      end
      // Status byte leaves MSB first on falling edges, repeating
      if (!q.paused && fall && q.reading) begin
        n.so_out = q.tx[7];
        n.driving = 1'b1;
        n.tx = (q.out_cnt == LAST_BIT) ? status_of(q) : {q.tx[6:0], 1'b0};
        n.out_cnt = q.out_cnt + 3'h1;
      end
    end
    // Output floats when deselected or paused
    n.so_oe = n.driving && !n.paused && !desel;
    n.quarters = protect_quarters({q.bph, q.bpl});
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.cs_s <= 2'h3;
      q.sck_prev <= 1'b0;
      q.hold_s <= 2'h3;
      q.wp_s <= 2'h3;
      q.phase <= ph_idle;
      q.pen <= NV_RESET;
      q.bph <= NV_RESET;
      q.bpl <= NV_RESET;
    end else begin
      q <= n;
    end
  end

  // Receive buffer toward the array path
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(q.push),
    .in_data(q.push_data),
    .in_ready(fifo_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  assign so_out = q.so_out;
  assign so_oe = q.so_oe;
  assign rx_overflow = q.overflow;
  assign write_busy = q.busy;
  assign array_quarters = q.quarters;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  desel_float_a: assert property (desel |=> !so_oe)
    else $error("output driven while deselected");
  pause_float_a: assert property (q.paused |-> !so_oe)
    else $error("output driven while paused");
  invalid_quiet_a: assert property (q.phase == ph_invalid && !desel |=>
    $stable(q.byte_cnt) && !so_oe)
    else $error("activity after invalid opcode");
  msb_first_a: assert property (rise && !q.paused && !desel && q.phase == ph_active |=>
    q.shift[0] == $past(q.si_s[1]))
    else $error("input bit not shifted in at lsb");
  first_drive_a: assert property ($rose(q.driving) |-> q.out_cnt == 3'h1 &&
    q.so_out == $past(q.tx[7]))
    else $error("first output bit wrong");
  write_runs_a: assert property (q.busy && q.wc_cnt != 20'(WRITE_CYCLES_P - 1) |=> q.busy)
    else $error("write cycle cut short");
  hold_abort_a: assert property (desel && q.phase != ph_idle && !q.hold_s[1] |=> !q.write_enable_latch)
    else $error("latch kept after paused deselect");
  status_guard_a: assert property (desel && (prot || !q.write_enable_latch) |=>
    $stable({q.pen, q.bph, q.bpl}))
    else $error("protected status changed");
  latch_clear_a: assert property (desel && q.phase == ph_active &&
    op_is(q.opcode, OP_LATCH_CLEAR) |=> !q.write_enable_latch)
    else $error("latch not cleared");
  latch_set_a: assert property (desel && q.phase == ph_active && q.hold_s[1] &&
    op_is(q.opcode, OP_LATCH_SET) |=> q.write_enable_latch)
    else $error("latch not set");
  status_write_a: assert property (desel && q.phase == ph_active &&
    op_is(q.opcode, OP_STATUS_WRITE) |=> q.write_enable_latch == $past(q.write_enable_latch))
    else $error("status write touched the latch");

  status_read_c: cover property (q.reading && q.out_cnt == LAST_BIT);
  latch_set_c: cover property (!q.write_enable_latch ##1 q.write_enable_latch);
  pause_c: cover property (q.paused && q.reading);
  write_cycle_c: cover property (q.busy ##1 !q.busy);
endmodule

// ### testbench/spi_master_model.sv
/*
 Serial bus master model for the EEPROM front end: select, clock, data and pause.
 Assumes a 125 MHz bench clock; pins change on its falling edges, 64 ns per bit.
*/
`timescale 1ns/100ps

module spi_master_model (
  input wire logic clock,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  ////////////////////////////////////////////////////////////////////////
  // Deselected, clock parked low, pause released
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Let a number of bench clock falls pass
  task automatic wait_fall(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Move select; a released data line shows no stale level
  task automatic select(input logic level);
    wait_fall(8);
    cs_n = level;
    if (level) si = ~si;
  endtask

  // Send one byte MSB first, clock high for four cycles per bit
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      wait_fall(4);
      sck = 1'b1;
      wait_fall(4);
      sck = 1'b0;
    end
  endtask

  // Move the pause pin while the clock is low
  task automatic pause(input logic level);
    wait_fall(2);
    hold_n = level;
  endtask
endmodule

// ### testbench/serial_eeprom_spi_command_front_end_bench.sv
/*
 Self-checking bench for the EEPROM front end: status, protection, pause, FIFO.
 Assumes the design package is compiled first and the master model beside it.
*/
`timescale 1ns/100ps

module serial_eeprom_spi_command_front_end_bench;
  import eeprom_spi_pkg::*;
  logic clock, rst, cs_n, sck, si, hold_n, wp_n, rx_ready;
  logic so_out, so_oe, rx_valid, rx_overflow, write_busy, oe_seen;
  logic [7:0] rx_data, shreg;
  logic [2:0] array_quarters;
  logic [31:0] lfsr;
  logic [7:0] stat_q[$];
  logic [7:0] fifo_q[$];
  int err_total, checked, nbit, ovf;

  ////////////////////////////////////////////////////////////////////////
  eeprom_spi_front_end #(.WRITE_CYCLES_P(400)) i_dut (.clock(clock), .rst(rst),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out),
    .so_oe(so_oe), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .rx_overflow(rx_overflow), .write_busy(write_busy), .array_quarters(array_quarters));
  spi_master_model i_master (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n));

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Close a frame; output must float once deselected
  task automatic frame_end;
    i_master.select(1'b1);
    i_master.wait_fall(6);
    check({7'h00, so_oe}, 8'h00, "float");
  endtask

  task automatic cmd(input logic [7:0] op);
    i_master.select(1'b0);
    i_master.xfer(op);
    frame_end();
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    stat_q.push_back(exp);
    i_master.select(1'b0);
    i_master.xfer(op);
    lfsr = lfsr_next(lfsr);
    i_master.xfer(lfsr[7:0]);
    frame_end();
  endtask

  task automatic wr_status(input logic [7:0] d);
    cmd(OP_LATCH_SET);
    i_master.select(1'b0);
    i_master.xfer(OP_STATUS_WRITE);
    i_master.xfer(d);
    frame_end();
  endtask

  // Wait for the internal write to finish, bounded
  task automatic wait_idle;
    for (int n = 0; n < 600 && write_busy !== 1'b0; n++) @(negedge clock);
    check({7'h00, write_busy}, 8'h00, "idle");
  endtask

  // Pop the FIFO under random back-pressure until every note is taken
  task automatic drain;
    for (int n = 0; n < 200 && fifo_q.size() > 0; n++) begin
      lfsr = lfsr_next(lfsr);
      rx_ready = lfsr[0];
      @(negedge clock);
    end
    rx_ready = 1'b0;
    i_master.wait_fall(2);
    check({7'h00, rx_valid}, 8'h00, "drained");
    check(fifo_q.size(), 8'h00, "count");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Collect reply bytes at clock falls and compare with the oldest note
  always @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      nbit = 0;
    end else if (so_oe === 1'b1) begin
      shreg = {shreg[6:0], so_out};
      nbit++;
      if (nbit == 8) begin
        nbit = 0;
        check(shreg, (stat_q.size() > 0) ? stat_q.pop_front() : 8'hXX, "status");
      end
    end
  end

  // Watch FIFO pops, overflow pulses and any output drive
  always @(posedge clock) begin
    if (so_oe === 1'b1) oe_seen <= 1'b1;
    if (rx_overflow === 1'b1) ovf++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      check(rx_data, (fifo_q.size() > 0) ? fifo_q.pop_front() : 8'hXX, "fifo");
    end
  end

  // Watchdog
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    rx_ready = 1'b0;
    oe_seen = 1'b0;
    lfsr = 32'h7E0FEFEC;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    rd(OP_STATUS_READ, 8'h00);
    cmd(8'h0E);
    rd(8'h0D, 8'h02);
    cmd(8'h0C);
    rd(OP_STATUS_READ, 8'h00);
    wr_status(8'hFF);
    check({7'h00, write_busy}, 8'h01, "busy");
    rd(OP_STATUS_READ, 8'hFF);
    wait_idle();
    rd(8'h05, 8'h8C);
    check({5'h00, array_quarters}, 8'h04, "quarters");
    wp_n = 1'b0;
    wr_status(8'h00);
    check({7'h00, write_busy}, 8'h00, "blocked");
    cmd(OP_LATCH_CLEAR);
    rd(OP_STATUS_READ, 8'h8C);
    wp_n = 1'b1;
    cmd(OP_LATCH_SET);
    i_master.select(1'b0);
    i_master.xfer(8'h09);
    i_master.xfer(8'h00);
    wp_n = 1'b0;
    i_master.wait_fall(8);
    wp_n = 1'b1;
    frame_end();
    rd(OP_STATUS_READ, 8'h8E);
    wp_n = 1'b1;
    wr_status(8'h04);
    wait_idle();
    check({5'h00, array_quarters}, 8'h01, "quarters");
    wp_n = 1'b0;
    wr_status(8'h08);
    wait_idle();
    rd(OP_STATUS_READ, 8'h08);
    check({5'h00, array_quarters}, 8'h02, "quarters");
    oe_seen = 1'b0;
    i_master.select(1'b0);
    i_master.xfer(8'hA5);
    i_master.xfer(OP_STATUS_READ);
    i_master.xfer(8'h00);
    frame_end();
    check({7'h00, oe_seen}, 8'h00, "invalid");
    stat_q.push_back(8'h08);
    i_master.select(1'b0);
    i_master.xfer(OP_STATUS_READ);
    i_master.pause(1'b0);
    i_master.wait_fall(8);
    check({7'h00, so_oe}, 8'h00, "paused");
    i_master.pause(1'b1);
    i_master.xfer(8'h00);
    frame_end();
    i_master.select(1'b0);
    i_master.xfer(OP_LATCH_SET);
    i_master.pause(1'b0);
    frame_end();
    i_master.pause(1'b1);
    rd(OP_STATUS_READ, 8'h08);
    cmd(OP_LATCH_SET);
    i_master.select(1'b0);
    i_master.xfer(OP_ARRAY_WRITE);
    for (int i = 0; i < 9; i++) begin
      lfsr = lfsr_next(lfsr);
      i_master.xfer(lfsr[7:0]);
      if (i < FIFO_DEPTH) fifo_q.push_back(lfsr[7:0]);
    end
    frame_end();
    check(ovf[7:0], 8'h01, "overflow");
    drain();
    wait_idle();
    // Array read: only the two address bytes reach the FIFO, output stays off
    oe_seen = 1'b0;
    i_master.select(1'b0);
    i_master.xfer(OP_ARRAY_READ);
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      i_master.xfer(lfsr[7:0]);
      if (i < 2) fifo_q.push_back(lfsr[7:0]);
    end
    frame_end();
    check({7'h00, oe_seen}, 8'h00, "read quiet");
    drain();
    print_verdict();
  end
endmodule
